// file: sim/ssr_smbus_master.sv
// smbus master model that performs byte reads on open-drain lines
`timescale 1ns/1ps
module ssr_smbus_master (
	input  wire logic sys_clk,
	input  wire logic sdaLine,
	output logic      sclLow,
	output logic      sdaLow
);
	int qLen = 10; // quarter bit in clocks, raised for a slow master

	// both lines released, pull-ups hold them high
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end

	// one quarter of a bit, inputs move just after the edge
	task automatic q;
		repeat (qLen) @(posedge sys_clk);
		#1;
	endtask

	// start or repeated start: sda falls while scl high
	task automatic startCond;
		sdaLow = 1'b0;
		q();
		sclLow = 1'b0;
		q();
		sdaLow = 1'b1;
		q();
		sclLow = 1'b1;
		q();
	endtask

	// one bit: data set with scl low, sampled in mid high
	task automatic bitIo(input logic b, output logic r);
		sdaLow = ~b;
		q();
		sclLow = 1'b0;
		q();
		r = sdaLine;
		q();
		sclLow = 1'b1;
		q();
	endtask

	// eight bits msb first, then the ninth acknowledge bit
	task automatic byteIo(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
		for (int i = 7; i >= 0; i--) begin
			bitIo(tx[i], rx[i]);
		end
		bitIo(ackIn, ackOut);
	endtask

	// full byte read; acks hold the three slave acknowledges, 0 = acked
	task automatic byteRead(input logic [6:0] addr, input logic [7:0] cmd, output logic [7:0] data, output logic [2:0] acks);
		logic [7:0] junk;
		logic       dummy;
		startCond();
		byteIo({addr, 1'b0}, 1'b1, junk, acks[2]);
		byteIo(cmd, 1'b1, junk, acks[1]);
		startCond();
		byteIo({addr, 1'b1}, 1'b1, junk, acks[0]);
		byteIo(8'hFF, 1'b1, data, dummy);
		sdaLow = 1'b1;
		q();
		sclLow = 1'b0;
		q();
		sdaLow = 1'b0;
		q();
	endtask
endmodule

// file: sim/ssr_status_slave_tb_top.sv
// self-checking bench for the status read slave
`timescale 1ns/1ps
`define CHK(nm_, ex_, gt_) begin checksDone++; if ((gt_) !== (ex_)) begin nFail++; $display("MISMATCH %s exp %h got %h", nm_, ex_, gt_); end end
module ssr_status_slave_tb_top;
	logic       sysClk = 1'b0;
	logic       rst_n = 1'b0;
	logic [6:0] addr = 7'h2A;
	logic       msgValid = 1'b0;
	logic [7:0] msgCmd = 8'h00;
	logic [2:0] powerState = 3'h0;
	logic [9:0] wdCount = 10'h000;
	logic       intrusion = 1'b0;
	logic       thermalN = 1'b1;
	logic       dead = 1'b0;
	logic       secTo = 1'b0;
	logic       alertN = 1'b1;
	logic       alertOff = 1'b0;
	logic       alertMode = 1'b1;
	logic       fwBlank = 1'b0;
	logic       batLowN = 1'b1;
	logic       smiClr = 1'b0;
	logic       sdaOut;
	logic       sdaOe;
	logic       smiFlag;
	logic       smiReq;
	logic       busBusy;
	logic       sclLow;
	logic       sdaLow;
	wire logic  sclLine;
	wire logic  sdaLine;
	int         nFail = 0;
	int         checksDone = 0;

	// open-drain wires with pull-ups
	assign sclLine = ~sclLow;
	assign sdaLine = ~sdaLow & ~(sdaOe & ~sdaOut);

	// 100 MHz clock
	always #5 sysClk = ~sysClk;

	ssr_status_slave ssr_status_slave_i (
		.sys_clk(sysClk), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine), .slaveAddr(addr),
		.msgValid(msgValid), .msgCmd(msgCmd), .powerState(powerState), .watchdogCount(wdCount),
		.coverIntrusionFlag(intrusion), .thermalAlarmIn_n(thermalN), .processorDead(dead),
		.watchdogSecondTimeoutFlag(secTo), .alertPinIn_n(alertN), .alertPinOff(alertOff),
		.alertPinMode(alertMode), .firmwareStoreBlank(fwBlank), .batteryLowIn_n(batLowN),
		.smiFlagClear(smiClr), .sdaOut(sdaOut), .sdaOe(sdaOe), .sidebandSmiFlag(smiFlag),
		.smiRequest(smiReq), .busBusy(busBusy)
	);

	ssr_smbus_master ssr_smbus_master_i (
		.sys_clk(sysClk), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow)
	);

	// verdict and end of run
	task automatic completeRun;
		if (nFail == 0 && checksDone > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// wait n clocks, then move just after the edge
	task automatic step(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask

	// one-cycle sideband message pulse
	task automatic sendMsg(input logic [7:0] cmd);
		msgValid = 1'b1;
		msgCmd = cmd;
		step(1);
		msgValid = 1'b0;
	endtask

	// byte read with all acks and the data byte compared
	task automatic doRead(input logic [7:0] cmd, input logic [7:0] exp, input string nm);
		logic [7:0] got;
		logic [2:0] acks;
		step(8);
		ssr_smbus_master_i.byteRead(addr, cmd, got, acks);
		`CHK("acks", 3'b000, acks)
		`CHK(nm, exp, got)
		`CHK("busBusy", 1'b0, busBusy)
	endtask

	// watchdog against a hang
	initial begin
		repeat (80000) @(posedge sysClk);
		nFail++;
		completeRun();
	end

	initial begin
		static logic [2:0] pwr [4] = '{ssr_pkg::PWR_S0, ssr_pkg::PWR_S3, ssr_pkg::PWR_S4, ssr_pkg::PWR_S5};
		static logic [9:0] wdIn [4] = '{10'h03E, 10'h03F, 10'h040, 10'h3FF};
		static logic [7:0] wdExp [4] = '{8'h3E, 8'h3F, 8'h3F, 8'h3F};
		static logic [7:0] evExp [7] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'h00, 8'h80, 8'h80};
		logic [7:0] got;
		logic [2:0] acks;
		step(5);
		rst_n = 1'b1;
		`CHK("sdaOe", 1'b0, sdaOe)
		`CHK("busBusy", 1'b0, busBusy)
		step(6);
		// smi message in working state sets the flag, request follows
		sendMsg(ssr_pkg::CMD_SIDEBAND_SMI);
		`CHK("flag", 1'b1, smiFlag)
		`CHK("smiReq", 1'b0, smiReq)
		step(1);
		`CHK("smiReq", 1'b1, smiReq)
		smiClr = 1'b1;
		step(1);
		smiClr = 1'b0;
		step(1);
		`CHK("flag", 1'b0, smiFlag)
		// other message type has no effect
		sendMsg(8'h07);
		step(1);
		`CHK("flag", 1'b0, smiFlag)
		// message while asleep is ignored
		powerState = ssr_pkg::PWR_S3;
		sendMsg(ssr_pkg::CMD_SIDEBAND_SMI);
		step(1);
		`CHK("flag", 1'b0, smiFlag)
		// flag set on the way out of S0 stays pending
		powerState = ssr_pkg::PWR_S0;
		sendMsg(ssr_pkg::CMD_SIDEBAND_SMI);
		powerState = ssr_pkg::PWR_S4;
		step(3);
		`CHK("flag", 1'b1, smiFlag)
		`CHK("smiReq", 1'b0, smiReq)
		powerState = ssr_pkg::PWR_S0;
		step(1);
		`CHK("smiReq", 1'b1, smiReq)
		smiClr = 1'b1;
		step(1);
		smiClr = 1'b0;
		// capability byte, read by a slow master
		ssr_smbus_master_i.qLen = 20;
		doRead(ssr_pkg::REG_CAPS, 8'h00, "caps");
		ssr_smbus_master_i.qLen = 10;
		doRead(ssr_pkg::REG_RSVD2, 8'h00, "rsvd2");
		doRead(8'h06, 8'h00, "unmapped06");
		doRead(8'hFF, 8'h00, "unmappedFF");
		for (int i = 0; i < 4; i++) begin
			powerState = pwr[i];
			doRead(ssr_pkg::REG_SLEEP, {5'h00, pwr[i]}, "sleep");
		end
		powerState = ssr_pkg::PWR_S0;
		for (int i = 0; i < 4; i++) begin
			wdCount = wdIn[i];
			doRead(ssr_pkg::REG_WDOG, wdExp[i], "wdog");
		end
		// one event input driven per step, with alertN high in steps 0 to 3; bit 7 reads set in every step but 4
		for (int k = 0; k < 7; k++) begin
			intrusion = (k == 0);
			thermalN = (k != 1);
			dead = (k == 2);
			secTo = (k == 3);
			alertN = (k < 4);
			alertOff = (k == 5);
			alertMode = (k != 6);
			doRead(ssr_pkg::REG_EVENT, evExp[k], "event");
		end
		fwBlank = 1'b1;
		doRead(ssr_pkg::REG_FWBAT, 8'h01, "fwbat");
		fwBlank = 1'b0;
		batLowN = 1'b0;
		doRead(ssr_pkg::REG_FWBAT, 8'h02, "fwbat");
		// wrong address is not acknowledged
		ssr_smbus_master_i.byteRead(7'h2B, ssr_pkg::REG_CAPS, got, acks);
		`CHK("nackAcks", 3'b111, acks)
		`CHK("nackData", 8'hFF, got)
		// value changing in mid data phase must not reach the wire
		wdCount = 10'h015;
		step(8);
		fork
			ssr_smbus_master_i.byteRead(addr, ssr_pkg::REG_WDOG, got, acks);
			begin
				step(1250);
				`CHK("busBusy", 1'b1, busBusy)
				wdCount = 10'h02A;
			end
		join
		`CHK("capture", 8'h15, got)
		completeRun();
	end
endmodule

// file: verilog/ssr_pkg.sv
// shared constants and types of the smbus status read slave
package ssr_pkg;

	// slave read register command codes
	localparam logic [7:0] REG_CAPS  = 8'h00;
	localparam logic [7:0] REG_SLEEP = 8'h01;
	localparam logic [7:0] REG_RSVD2 = 8'h02;
	localparam logic [7:0] REG_WDOG  = 8'h03;
	localparam logic [7:0] REG_EVENT = 8'h04;
	localparam logic [7:0] REG_FWBAT = 8'h05;

	// sideband message command type that requests an smi
	localparam logic [7:0] CMD_SIDEBAND_SMI = 8'h08;

	// power state encodings
	localparam logic [2:0] PWR_S0 = 3'h0;
	localparam logic [2:0] PWR_S3 = 3'h3;
	localparam logic [2:0] PWR_S4 = 3'h4;
	localparam logic [2:0] PWR_S5 = 3'h5;

	// watchdog view saturation
	localparam logic [9:0] WD_SAT     = 10'h03F;
	localparam int         WD_FIELD_W = 6;

	// event register bit positions
	localparam int EVT_INTRUSION = 0;
	localparam int EVT_THERMAL   = 1;
	localparam int EVT_DEAD      = 2;
	localparam int EVT_SECOND_TO = 3;
	localparam int EVT_ALERT     = 7;

	// firmware / battery register bit positions
	localparam int FWB_BLANK   = 0;
	localparam int FWB_BATTERY = 1;

	// misc values
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [3:0] BIT_ZERO  = 4'h0;
	localparam logic [3:0] BIT_ONE   = 4'h1;
	localparam logic [3:0] LAST_BIT  = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// bus engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK,
		ST_WAIT
	} ssr_state_t;

	// which byte of the byte read is being received
	typedef enum logic [1:0] {
		SEL_ADDR1,
		SEL_CMD,
		SEL_ADDR2
	} ssr_sel_t;

endpackage

// file: verilog/ssr_reg_map.sv
// read value selection for the slave read registers
`timescale 1ns/1ps
module ssr_reg_map (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] cmdCode,
	ssr_status_if.dst       st,
	output logic [7:0]      readData
);
	logic [9:0] wdView;

	// saturating watchdog view
	always_comb begin
		wdView = (st.watchdogCount > ssr_pkg::WD_SAT) ? ssr_pkg::WD_SAT : st.watchdogCount;
	end

	// register decode, unmapped codes read zero
	always_comb begin
		readData = ssr_pkg::ZERO_BYTE;
		case (cmdCode)
			ssr_pkg::REG_CAPS: readData = ssr_pkg::ZERO_BYTE;
			ssr_pkg::REG_SLEEP: readData = {5'h00, st.powerState};
			ssr_pkg::REG_WDOG: readData = {2'h0, wdView[ssr_pkg::WD_FIELD_W-1:0]};
			ssr_pkg::REG_EVENT: begin
				readData[ssr_pkg::EVT_INTRUSION] = st.coverIntrusionFlag;
				readData[ssr_pkg::EVT_THERMAL]   = st.thermalActive;
				readData[ssr_pkg::EVT_DEAD]      = st.processorDead;
				readData[ssr_pkg::EVT_SECOND_TO] = st.secondTimeoutFlag;
				readData[ssr_pkg::EVT_ALERT]     = st.alertPinOff | ~st.alertPinMode | st.alertLevel;
			end
			ssr_pkg::REG_FWBAT: begin
				readData[ssr_pkg::FWB_BLANK]   = st.firmwareStoreBlank;
				readData[ssr_pkg::FWB_BATTERY] = st.batteryLow;
			end
			default: readData = ssr_pkg::ZERO_BYTE;
		endcase
	end

	property p_caps_zero;
		@(posedge sys_clk) disable iff (!rst_n) (cmdCode == ssr_pkg::REG_CAPS) |-> (readData == ssr_pkg::ZERO_BYTE);
	endproperty
	a_caps_zero: assert property (p_caps_zero) else $error("capability byte not zero");

	property p_wd_sat;
		@(posedge sys_clk) disable iff (!rst_n)
			(cmdCode == ssr_pkg::REG_WDOG && st.watchdogCount > ssr_pkg::WD_SAT) |-> (readData == 8'h3F);
	endproperty
	a_wd_sat: assert property (p_wd_sat) else $error("watchdog view not saturated");

	property p_evt_rsvd;
		@(posedge sys_clk) disable iff (!rst_n) (cmdCode == ssr_pkg::REG_EVENT) |-> (readData[6:4] == 3'h0);
	endproperty
	a_evt_rsvd: assert property (p_evt_rsvd) else $error("event reserved bits set");

	property p_alert_off;
		@(posedge sys_clk) disable iff (!rst_n)
			(cmdCode == ssr_pkg::REG_EVENT && st.alertPinOff) |-> readData[ssr_pkg::EVT_ALERT];
	endproperty
	a_alert_off: assert property (p_alert_off) else $error("alert bit low while disabled");

	property p_battery;
		@(posedge sys_clk) disable iff (!rst_n)
			(cmdCode == ssr_pkg::REG_FWBAT) |-> (readData[ssr_pkg::FWB_BATTERY] == st.batteryLow);
	endproperty
	a_battery: assert property (p_battery) else $error("battery bit mismatch");
endmodule

// file: verilog/ssr_status_if.sv
// status bits handed from the slave top to the register map
`timescale 1ns/1ps
interface ssr_status_if;
	logic [2:0] powerState;
	logic [9:0] watchdogCount;
	logic       coverIntrusionFlag;
	logic       thermalActive;
	logic       processorDead;
	logic       secondTimeoutFlag;
	logic       alertLevel;
	logic       alertPinOff;
	logic       alertPinMode;
	logic       firmwareStoreBlank;
	logic       batteryLow;

	modport src (
		output powerState, watchdogCount, coverIntrusionFlag, thermalActive, processorDead,
		output secondTimeoutFlag, alertLevel, alertPinOff, alertPinMode, firmwareStoreBlank, batteryLow
	);
	modport dst (
		input powerState, watchdogCount, coverIntrusionFlag, thermalActive, processorDead,
		input secondTimeoutFlag, alertLevel, alertPinOff, alertPinMode, firmwareStoreBlank, batteryLow
	);
endinterface

// file: verilog/ssr_status_slave.sv
// smbus slave status byte read and sideband smi flag
`timescale 1ns/1ps
module ssr_status_slave (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	input  wire logic [6:0] slaveAddr,
	input  wire logic       msgValid,
	input  wire logic [7:0] msgCmd,
	input  wire logic [2:0] powerState,
	input  wire logic [9:0] watchdogCount,
	input  wire logic       coverIntrusionFlag,
	input  wire logic       thermalAlarmIn_n,
	input  wire logic       processorDead,
	input  wire logic       watchdogSecondTimeoutFlag,
	input  wire logic       alertPinIn_n,
	input  wire logic       alertPinOff,
	input  wire logic       alertPinMode,
	input  wire logic       firmwareStoreBlank,
	input  wire logic       batteryLowIn_n,
	input  wire logic       smiFlagClear,
	output logic            sdaOut,
	output logic            sdaOe,
	output logic            sidebandSmiFlag,
	output logic            smiRequest,
	output logic            busBusy
);

	ssr_pkg::ssr_state_t state_q;
	ssr_pkg::ssr_sel_t   byteSel_q;

	logic [3:0] bitCnt_q;
	logic [7:0] rxShift_q;
	logic [7:0] txShift_q;
	logic [7:0] cmdReg_q;
	logic       cmdSeen_q;
	logic       sclPrev_q;
	logic       sdaPrev_q;

	logic       sclS;
	logic       sdaS;
	logic       thermS;
	logic       alertS;
	logic       batS;
	logic [7:0] readData;

	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic byteDone;
	logic addrMatch;
	logic ackGo;
	logic ackEnd;
	logic txStep;
	logic txLast;
	logic inS0;
	logic smiSet;

	// pin synchronisers
	ssr_sync3 #(
		.RESET_VAL (1'b1)
	) u_sclSync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pinIn    (sclIn),
		.levelOut (sclS)
	);

	ssr_sync3 #(
		.RESET_VAL (1'b1)
	) u_sdaSync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pinIn    (sdaIn),
		.levelOut (sdaS)
	);

	ssr_sync3 #(
		.RESET_VAL (1'b1)
	) u_thermSync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pinIn    (thermalAlarmIn_n),
		.levelOut (thermS)
	);

	ssr_sync3 #(
		.RESET_VAL (1'b1)
	) u_alertSync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pinIn    (alertPinIn_n),
		.levelOut (alertS)
	);

	ssr_sync3 #(
		.RESET_VAL (1'b1)
	) u_batSync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pinIn    (batteryLowIn_n),
		.levelOut (batS)
	);

	// status bits toward the register map
	ssr_status_if stIf ();

	assign stIf.powerState         = powerState;
	assign stIf.watchdogCount      = watchdogCount;
	assign stIf.coverIntrusionFlag = coverIntrusionFlag;
	assign stIf.thermalActive      = ~thermS;
	assign stIf.processorDead      = processorDead;
	assign stIf.secondTimeoutFlag  = watchdogSecondTimeoutFlag;
	assign stIf.alertLevel         = alertS;
	assign stIf.alertPinOff        = alertPinOff;
	assign stIf.alertPinMode       = alertPinMode;
	assign stIf.firmwareStoreBlank = firmwareStoreBlank;
	assign stIf.batteryLow         = ~batS;

	// command code picks the register
	ssr_reg_map u_regMap (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.cmdCode  (cmdReg_q),
		.st       (stIf),
		.readData (readData)
	);

	// previous line levels for edge detection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	// bus events and engine strobes
	assign sclRise   = sclS & ~sclPrev_q;
	assign sclFall   = ~sclS & sclPrev_q;
	assign startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
	assign stopSeen  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
	assign byteDone  = (state_q == ssr_pkg::ST_RX) && sclFall && (bitCnt_q == ssr_pkg::BYTE_BITS);
	assign addrMatch = (rxShift_q[7:1] == slaveAddr);
	assign ackGo     = byteDone && ((byteSel_q == ssr_pkg::SEL_CMD) || addrMatch);
	assign ackEnd    = (state_q == ssr_pkg::ST_ACK) && sclFall;
	assign txStep    = (state_q == ssr_pkg::ST_TX) && sclFall;
	assign txLast    = txStep && (bitCnt_q == ssr_pkg::LAST_BIT);

	// main engine: state, byte selector, bit count
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= ssr_pkg::ST_IDLE;
			byteSel_q <= ssr_pkg::SEL_ADDR1;
			bitCnt_q  <= ssr_pkg::BIT_ZERO;
			cmdSeen_q <= 1'b0;
		end else if (startSeen) begin
			// restart after a command goes to the read address
			state_q   <= ssr_pkg::ST_RX;
			byteSel_q <= cmdSeen_q ? ssr_pkg::SEL_ADDR2 : ssr_pkg::SEL_ADDR1;
			bitCnt_q  <= ssr_pkg::BIT_ZERO;
			cmdSeen_q <= 1'b0;
		end else if (stopSeen) begin
			state_q   <= ssr_pkg::ST_IDLE;
			bitCnt_q  <= ssr_pkg::BIT_ZERO;
			cmdSeen_q <= 1'b0;
		end else begin
			case (state_q)
				ssr_pkg::ST_RX: begin
					if (sclRise && bitCnt_q != ssr_pkg::BYTE_BITS) begin
						bitCnt_q <= bitCnt_q + ssr_pkg::BIT_ONE;
					end else if (byteDone) begin
						state_q <= ackGo ? ssr_pkg::ST_ACK : ssr_pkg::ST_WAIT;
					end
				end
				ssr_pkg::ST_ACK: begin
					if (ackEnd) begin
						bitCnt_q <= ssr_pkg::BIT_ZERO;
						case (byteSel_q)
							ssr_pkg::SEL_ADDR1: begin
								state_q   <= ssr_pkg::ST_RX;
								byteSel_q <= ssr_pkg::SEL_CMD;
							end
							ssr_pkg::SEL_CMD: begin
								state_q   <= ssr_pkg::ST_WAIT;
								cmdSeen_q <= 1'b1;
							end
							default: begin
								state_q <= ssr_pkg::ST_TX;
							end
						endcase
					end
				end
				ssr_pkg::ST_TX: begin
					if (txLast) begin
						state_q <= ssr_pkg::ST_MACK;
					end else if (txStep) begin
						bitCnt_q <= bitCnt_q + ssr_pkg::BIT_ONE;
					end
				end
				ssr_pkg::ST_MACK: begin
					// master nack expected, then stop
					if (sclRise) begin
						state_q <= ssr_pkg::ST_WAIT;
					end
				end
				ssr_pkg::ST_WAIT: begin
					state_q <= ssr_pkg::ST_WAIT;
				end
				default: begin
					state_q <= ssr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// receive shifter, samples on rising scl
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxShift_q <= ssr_pkg::ZERO_BYTE;
		end else if (state_q == ssr_pkg::ST_RX && sclRise && bitCnt_q != ssr_pkg::BYTE_BITS) begin
			rxShift_q <= {rxShift_q[6:0], sdaS};
		end
	end

	// command code latch
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmdReg_q <= ssr_pkg::ZERO_BYTE;
		end else if (ackGo && byteSel_q == ssr_pkg::SEL_CMD) begin
			cmdReg_q <= rxShift_q;
		end
	end

	// transmit shifter, captured at the read address ack
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			txShift_q <= ssr_pkg::ZERO_BYTE;
		end else if (ackGo && byteSel_q == ssr_pkg::SEL_ADDR2) begin
			txShift_q <= readData;
		end else if (txStep && !txLast) begin
			txShift_q <= {txShift_q[6:0], 1'b0};
		end
	end

	// open drain data drive, changes on falling scl
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdaOe <= 1'b0;
		end else if (startSeen || stopSeen) begin
			sdaOe <= 1'b0;
		end else if (ackGo) begin
			sdaOe <= 1'b1;
		end else if (ackEnd) begin
			sdaOe <= (byteSel_q == ssr_pkg::SEL_ADDR2) ? ~txShift_q[7] : 1'b0;
		end else if (txLast) begin
			sdaOe <= 1'b0;
		end else if (txStep) begin
			sdaOe <= ~txShift_q[6];
		end
	end

	// pin only ever pulls low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

	// bus busy between start and stop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busBusy <= 1'b0;
		end else if (startSeen) begin
			busBusy <= 1'b1;
		end else if (stopSeen) begin
			busBusy <= 1'b0;
		end
	end

	// sideband smi flag, set wins over clear
	assign inS0   = (powerState == ssr_pkg::PWR_S0);
	assign smiSet = msgValid && (msgCmd == ssr_pkg::CMD_SIDEBAND_SMI) && inS0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sidebandSmiFlag <= 1'b0;
		end else begin
			sidebandSmiFlag <= smiSet | (sidebandSmiFlag & ~smiFlagClear);
		end
	end

	// smi request only while in S0
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			smiRequest <= 1'b0;
		end else begin
			smiRequest <= sidebandSmiFlag & inS0;
		end
	end

	sequence s_smi_msg;
		msgValid && (msgCmd == ssr_pkg::CMD_SIDEBAND_SMI);
	endsequence

	sequence s_byte_done;
		(state_q == ssr_pkg::ST_RX) && sclFall && (bitCnt_q == ssr_pkg::BYTE_BITS);
	endsequence

	property p_smi_set;
		@(posedge sys_clk) disable iff (!rst_n) (s_smi_msg and inS0) |=> sidebandSmiFlag;
	endproperty
	a_smi_set: assert property (p_smi_set) else $error("smi flag not set in S0");

	property p_smi_sleep;
		@(posedge sys_clk) disable iff (!rst_n)
			(s_smi_msg and (!inS0 && !sidebandSmiFlag)) |=> !sidebandSmiFlag;
	endproperty
	a_smi_sleep: assert property (p_smi_sleep) else $error("smi flag set while asleep");

	property p_smi_pending;
		@(posedge sys_clk) disable iff (!rst_n)
			(sidebandSmiFlag && !smiFlagClear && !inS0) ##1 (inS0 && !smiFlagClear) |=> smiRequest;
	endproperty
	a_smi_pending: assert property (p_smi_pending) else $error("pending smi not raised");

	property p_ack_cmd;
		@(posedge sys_clk) disable iff (!rst_n)
			(s_byte_done and (byteSel_q == ssr_pkg::SEL_CMD) && !startSeen && !stopSeen) |=> sdaOe;
	endproperty
	a_ack_cmd: assert property (p_ack_cmd) else $error("command byte not acked");

	property p_no_ack_mismatch;
		@(posedge sys_clk) disable iff (!rst_n)
			(s_byte_done and (byteSel_q != ssr_pkg::SEL_CMD) && !addrMatch) |=> !sdaOe;
	endproperty
	a_no_ack_mismatch: assert property (p_no_ack_mismatch) else $error("foreign address acked");

	property p_tx_stable;
		@(posedge sys_clk) disable iff (!rst_n)
			(state_q == ssr_pkg::ST_TX && !sclFall && !startSeen && !stopSeen) |=> $stable(txShift_q);
	endproperty
	a_tx_stable: assert property (p_tx_stable) else $error("data byte changed mid bit");

	property p_release_after_data;
		@(posedge sys_clk) disable iff (!rst_n) txLast |=> (!sdaOe && state_q == ssr_pkg::ST_MACK);
	endproperty
	a_release_after_data: assert property (p_release_after_data) else $error("sda held past data");

endmodule

// file: verilog/ssr_sync3.sv
// three flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module ssr_sync3 #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic pinIn,
	output logic      levelOut
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// chain; first stage only feeds the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// accept a change once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			levelOut <= RESET_VAL;
		end else if (s2_q == s3_q) begin
			levelOut <= s3_q;
		end
	end
endmodule
